// ---- logic/io_port_watchdog_timer.sv ----
`timescale 1ns/10ps
// Purpose: Watchdog reached through one byte-wide I/O port
// Assumes: I/O strobes are one-cycle pulses synchronous to clk_sys_in
// Notes:   Expiry drives a reset pulse or an interrupt level
// Operation
// - On expiry without refresh, reset the CPU or raise an interrupt.
// - A write to the watchdog port starts it with the written interval.
// - Codes 01h to 3Eh give one to sixty-two seconds.
// - Rewriting the port restarts the full timeout.
// - A read of the port stops the watchdog.
module io_port_watchdog_timer
	import io_wdt_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int RST_CYC  = RESET_PULSE_CYC
) (
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic        io_wr_in,
	input  wire logic        io_rd_in,
	input  wire logic [7:0]  io_wdata_in,
	input  wire logic        expiry_irq_sel_in,
	output logic      [7:0]  io_rdata_out,
	output logic             io_sel_out,
	output logic             cpu_reset_out,
	output logic             irq_out,
	output logic             running_out
);
	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_RUN  = 2'b01,
		ST_FIRE = 2'b10
	} wdt_state_t;

	////////////////////////////////////////////////////////////////////
	wdt_state_t  state_r;
	wdt_state_t  state_nxt;
	logic [7:0]  interval_r;
	logic [7:0]  interval_nxt;
	logic [7:0]  remain_r;
	logic [7:0]  remain_nxt;
	logic [7:0]  pulse_r;
	logic [7:0]  pulse_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic        rst_r;
	logic        rst_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic [7:0]  rst_len_r;
	logic [7:0]  rst_len_nxt;
	logic        hit;
	logic        wr_hit;
	logic        rd_hit;
	logic        code_ok;

	io_wdt_tick_if tk();

	io_wdt_tick_div #(
		.DIV_CYCLES (TICK_DIV)
	) u_div (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.tk         (tk)
	);

	assign hit     = (io_addr_in == WDT_PORT_ADDR);
	assign wr_hit  = hit && io_wr_in;
	assign rd_hit  = hit && io_rd_in;
	// Out-of-range codes are ignored rather than guessed at
	assign code_ok = (io_wdata_in >= WDT_CODE_MIN) && (io_wdata_in <= WDT_CODE_MAX);
	assign tk.restart = wr_hit && code_ok;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt    = state_r;
		interval_nxt = interval_r;
		remain_nxt   = remain_r;
		pulse_nxt    = pulse_r;
		irq_nxt      = irq_r;
		rst_nxt      = rst_r;
		rdata_nxt    = rd_hit ? interval_r : rdata_r;
		if (rd_hit) begin
			// Read wins over a same-cycle write: disabling is the safe side
			state_nxt = ST_OFF;
			irq_nxt   = 1'b0;
			rst_nxt   = 1'b0;
			pulse_nxt = 8'h00;
		end else if (wr_hit && code_ok) begin
			interval_nxt = io_wdata_in;
			remain_nxt   = io_wdata_in;
			state_nxt    = ST_RUN;
			irq_nxt      = 1'b0;
			// Refresh cuts a reset pulse short rather than leaving it stuck high
			rst_nxt      = 1'b0;
			pulse_nxt    = 8'h00;
		end else begin
			unique case (state_r)
				ST_OFF: begin
				end
				ST_RUN: begin
					if (tk.tick) begin
						if (remain_r == 8'h01) begin
							state_nxt = ST_FIRE;
							if (expiry_irq_sel_in) begin
								irq_nxt = 1'b1;
							end else begin
								rst_nxt   = 1'b1;
								pulse_nxt = 8'(RST_CYC - 1);
							end
						end else begin
							remain_nxt = remain_r - 8'h01;
						end
					end
				end
				ST_FIRE: begin
					// Interrupt holds until the next in-range write or a read
					if (rst_r) begin
						if (pulse_r == 8'h00) begin
							rst_nxt   = 1'b0;
							state_nxt = ST_OFF;
						end else begin
							pulse_nxt = pulse_r - 8'h01;
						end
					end
				end
				default: state_nxt = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r    <= ST_OFF;
			interval_r <= WDT_CODE_RESET;
			remain_r   <= WDT_CODE_RESET;
			pulse_r    <= 8'h00;
			irq_r      <= 1'b0;
			rst_r      <= 1'b0;
			rdata_r    <= 8'h00;
		end else begin
			state_r    <= state_nxt;
			interval_r <= interval_nxt;
			remain_r   <= remain_nxt;
			pulse_r    <= pulse_nxt;
			irq_r      <= irq_nxt;
			rst_r      <= rst_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	assign io_rdata_out  = rdata_r;
	assign io_sel_out    = hit && (io_wr_in || io_rd_in);
	assign cpu_reset_out = rst_r;
	assign irq_out       = irq_r;
	assign running_out   = (state_r == ST_RUN);

	////////////////////////////////////////////////////////////////////
	// Pulse length count for the checks only; nothing else reads it
	always_comb begin
		rst_len_nxt = rst_r ? rst_len_r + 8'h01 : 8'h00;
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_len_r <= 8'h00;
		end else begin
			rst_len_r <= rst_len_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	chk_read_stops: assert property (rd_hit |=> state_r == ST_OFF && !irq_r && !rst_r)
		else $error("read did not stop watchdog");
	chk_write_loads: assert property (wr_hit && code_ok && !rd_hit |=> running_out && remain_r == $past(io_wdata_in))
		else $error("write did not load interval");
	chk_bad_code: assert property (wr_hit && !code_ok && !rd_hit && state_r == ST_OFF |=> state_r == ST_OFF)
		else $error("bad code started watchdog");
	chk_store_code: assert property (wr_hit && code_ok && !rd_hit |=> interval_r == $past(io_wdata_in))
		else $error("interval not stored");
	chk_expire_irq: assert property (state_r == ST_RUN && tk.tick && remain_r == 8'h01 && expiry_irq_sel_in && !io_sel_out
		|=> irq_r && !rst_r)
		else $error("expiry missed interrupt");
	chk_expire_rst: assert property (state_r == ST_RUN && tk.tick && remain_r == 8'h01 && !expiry_irq_sel_in && !io_sel_out
		|=> rst_r && !irq_r)
		else $error("expiry missed reset");
	chk_no_early: assert property (state_r == ST_RUN && remain_r > 8'h01 |=> !rst_r && !irq_r)
		else $error("early expiry");
	chk_off_quiet: assert property (state_r == ST_OFF && !wr_hit |=> !running_out && !irq_r)
		else $error("disabled watchdog active");
	chk_refresh_phase: assert property (tk.restart |=> !tk.tick)
		else $error("refresh did not re-phase tick");
	chk_irq_holds: assert property (irq_r && !rd_hit && !tk.restart
		|=> irq_r)
		else $error("interrupt dropped without access");
	chk_read_data: assert property (rd_hit |=> io_rdata_out == $past(interval_r))
		else $error("read data not stored interval");
	chk_irq_source: assert property ($rose(irq_r)
		|-> $past(state_r) == ST_RUN && $past(remain_r) == 8'h01 && $past(tk.tick))
		else $error("interrupt without expiry");
	chk_rst_width: assert property ($fell(rst_r) && !$past(rd_hit) && !$past(tk.restart)
		|-> rst_len_r == 8'(RST_CYC))
		else $error("reset pulse wrong length");
	chk_rst_bound: assert property (rst_len_r <= 8'(RST_CYC))
		else $error("reset pulse too long");
	chk_pulse_off: assert property ($fell(rst_r) && !$past(tk.restart) |-> state_r == ST_OFF)
		else $error("watchdog not off after reset pulse");
	chk_code_range: assert property (running_out |-> interval_r >= WDT_CODE_MIN && interval_r <= WDT_CODE_MAX)
		else $error("running with bad interval");
	chk_remain_bound: assert property (running_out |-> remain_r != 8'h00 && remain_r <= interval_r)
		else $error("remaining count out of range");

	cov_irq:     cover property (state_r == ST_RUN ##1 irq_r);
	cov_rst:     cover property (state_r == ST_RUN ##1 rst_r);
	cov_refresh: cover property (running_out && wr_hit && code_ok);
	cov_disable: cover property (running_out && rd_hit);
	cov_rd_wr:   cover property (rd_hit && tk.restart);
endmodule : io_port_watchdog_timer

// ---- logic/io_wdt_pkg.sv ----
// Purpose: Constants for the I/O port watchdog
// Assumes: 10 MHz system clock, byte-wide I/O port access
// Notes:   Tick count derives from the clock rate; reset pulse is a fixed 16 cycles
package io_wdt_pkg;
	localparam logic [15:0] WDT_PORT_ADDR    = 16'h0443;
	localparam logic [7:0]  WDT_CODE_MIN     = 8'h01;
	localparam logic [7:0]  WDT_CODE_MAX     = 8'h3E;
	localparam logic [7:0]  WDT_CODE_RESET   = 8'h00;
	localparam int          CLK_HZ           = 10000000;
	localparam int          TICK_PERIOD_S    = 1;
	localparam int          TICK_CYCLES      = CLK_HZ * TICK_PERIOD_S;
	localparam int          RESET_PULSE_CYC  = 16;
endpackage : io_wdt_pkg

// ---- logic/io_wdt_tick_div.sv ----
`timescale 1ns/10ps
// Purpose: One-second enable pulse from the system clock
// Assumes: Restart is a one-cycle pulse
// Notes:   Restart clears phase so a full second follows a write
module io_wdt_tick_div
	import io_wdt_pkg::*;
#(
	parameter int DIV_CYCLES = TICK_CYCLES
) (
	input  wire logic   clk_sys_in,
	input  wire logic   resetn_in,
	io_wdt_tick_if.div  tk
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        tick_nxt;
	logic        tick_r;

	always_comb begin
		tick_nxt = 1'b0;
		if (tk.restart) begin
			cnt_nxt = 32'h00000000;
		end else if (cnt_r == 32'(DIV_CYCLES - 1)) begin
			cnt_nxt  = 32'h00000000;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 32'h00000001;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r  <= 32'h00000000;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tk.tick = tick_r;
endmodule : io_wdt_tick_div

// ---- logic/io_wdt_tick_if.sv ----
`timescale 1ns/10ps
// Purpose: Carrier between the tick divider and the watchdog core
// Assumes: Single clock domain
// Notes:   Restart re-phases the divider
interface io_wdt_tick_if;
	logic restart;
	logic tick;
	modport core (output restart, input tick);
	modport div  (input restart, output tick);
endinterface : io_wdt_tick_if

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the I/O port watchdog
// Assumes: TICK_DIV shortened to 10 cycles per second tick
// Notes:   Read results go through a queue of expected values
`timescale 1ns/10ps
module tb_top;
	import io_wdt_pkg::*;
	localparam int TD = 10;
	logic        clk_sys_in = 1'b0;
	logic        resetn_in  = 1'b0;
	logic [15:0] io_addr_in = 16'h0000;
	logic        io_wr_in   = 1'b0;
	logic        io_rd_in   = 1'b0;
	logic [7:0]  io_wdata_in = 8'h00;
	logic        sel_irq    = 1'b1;
	logic [7:0]  io_rdata_out;
	logic        io_sel_out, cpu_reset_out, irq_out, running_out, rd_d;
	logic [7:0]  exp_q[$];
	logic [7:0]  code;
	int          errors = 0;
	int          n_compared = 0;
	int          n;
	io_port_watchdog_timer #(.TICK_DIV(TD)) DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
		.expiry_irq_sel_in(sel_irq), .io_rdata_out(io_rdata_out), .io_sel_out(io_sel_out),
		.cpu_reset_out(cpu_reset_out), .irq_out(irq_out), .running_out(running_out));
	always #50 clk_sys_in = ~clk_sys_in;
	////////////////////////////////////////////////////////////////
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	// One-cycle strobe, returns just after the taking edge
	task io(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		io_wr_in    <= w;
		io_rd_in    <= r;
		io_addr_in  <= a;
		io_wdata_in <= d;
		#1;
		check(8'(io_sel_out), 8'((a == WDT_PORT_ADDR) && (w || r)));
		@(posedge clk_sys_in);
		io_wr_in <= 1'b0;
		io_rd_in <= 1'b0;
		#1;
	endtask : io
	task rd_port(input logic [7:0] exp);
		exp_q.push_back(exp);
		io(1'b0, 1'b1, WDT_PORT_ADDR, 8'h00);
	endtask : rd_port
	task cycles(input int c);
		repeat (c) @(posedge clk_sys_in);
		#1;
	endtask : cycles
	// Bounded wait for either expiry output
	task wait_exp(input int lim);
		n = 0;
		while (irq_out !== 1'b1 && cpu_reset_out !== 1'b1 && n < lim) begin
			cycles(1);
			n++;
		end
	endtask : wait_exp
	////////////////////////////////////////////////////////////////
	always @(posedge clk_sys_in) begin
		rd_d <= io_rd_in && io_addr_in == WDT_PORT_ADDR;
		if (rd_d === 1'b1 && exp_q.size() > 0) check(io_rdata_out, exp_q.pop_front());
	end
	initial begin
		#(100 * 5000);
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(79876));
		cycles(3);
		resetn_in <= 1'b1;
		check({running_out, irq_out, cpu_reset_out}, 8'h00);
		io(1'b1, 1'b0, 16'h0442, 8'h05);
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h00);
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h3F);
		check(running_out, 1'b0);
		$display("test ignored writes done");
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h03);
		check(running_out, 1'b1);
		cycles(3 * TD - 3);
		check(irq_out, 1'b0);
		wait_exp(8);
		check({irq_out, running_out}, 8'h02);
		rd_port(8'h03);
		check({irq_out, running_out}, 8'h00);
		$display("test interrupt expiry done");
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h02);
		cycles(15);
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h02);
		cycles(15);
		check({irq_out, running_out}, 8'h01);
		rd_port(8'h02);
		check(running_out, 1'b0);
		$display("test refresh done");
		code = 8'h01 + 8'($urandom % 62);
		io(1'b1, 1'b0, WDT_PORT_ADDR, code);
		rd_port(code);
		io(1'b1, 1'b0, WDT_PORT_ADDR, WDT_CODE_MAX);
		rd_port(WDT_CODE_MAX);
		$display("test random code done");
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h04);
		exp_q.push_back(8'h04);
		io(1'b1, 1'b1, WDT_PORT_ADDR, 8'h05);
		check(running_out, 1'b0);
		$display("test read beats write done");
		io(1'b1, 1'b0, WDT_PORT_ADDR, 8'h05);
		cycles(5);
		resetn_in <= 1'b0;
		cycles(3);
		check({running_out, irq_out, cpu_reset_out}, 8'h00);
		resetn_in <= 1'b1;
		rd_port(WDT_CODE_RESET);
		check(running_out, 1'b0);
		$display("test mid-run reset done");
		sel_irq <= 1'b0;
		io(1'b1, 1'b0, WDT_PORT_ADDR, WDT_CODE_MIN);
		wait_exp(TD + 8);
		check({cpu_reset_out, irq_out}, 8'h02);
		n = 0;
		while (cpu_reset_out === 1'b1 && n < 40) begin
			cycles(1);
			n++;
		end
		check(8'(n), 8'(RESET_PULSE_CYC));
		check(running_out, 1'b0);
		$display("test reset expiry done");
		cycles(2);
		summarize();
	end
endmodule : tb_top
